// ---- core/tcs_pkg.sv ----
package tcs_pkg;
    // register address and width
    localparam logic [3:0]  TCS_ADDR_CFG0      = 4'h0;
    localparam int          TCS_DATA_W         = 16;
    // field positions in touch_config_zero
    localparam int          TCS_BIT_MODE       = 15;
    localparam int          TCS_BIT_STOP       = 14;
    localparam int          TCS_BIT_RES        = 13;
    localparam int          TCS_CLK_HI         = 12;
    localparam int          TCS_CLK_LO         = 11;
    localparam int          TCS_SETTLE_HI      = 10;
    localparam int          TCS_SETTLE_LO      = 8;
    localparam int          TCS_LOW_HI         = 7;
    // reset values: read view and written control state
    localparam logic [15:0] TCS_RESET_READ     = 16'h4000;
    localparam logic [15:0] TCS_RESET_WRITE    = 16'h0000;
    // function codes allowed with self-initiated scans
    localparam logic [3:0]  TCS_FUNC_XYZ_SCAN  = 4'h0;
    localparam logic [3:0]  TCS_FUNC_XY_SCAN   = 4'h1;
    // stop sequencer states
    typedef enum logic [1:0] {
        TCS_ST_RUN  = 2'b01,
        TCS_ST_STOP = 2'b10
    } tcs_state_t;
endpackage : tcs_pkg

// ---- core/tcs_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for an asynchronous level
module tcs_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    // first stage feeds only the second stage
    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule : tcs_sync

// ---- core/tcs_config_status.sv ----
// Functional notes
// RQ1: reads of the register return bit 15 as 1 while the screen is touched and 0 otherwise.
// RQ2: the written mode bit chooses host-controlled conversions (0) or device-initiated scans on pen touch (1).
// RQ3: the written mode bit is 0 after reset, so host control is the default.
// RQ4: the host uses device-initiated scans only with function code 0000 (XYZ) or 0001 (XY).
// RQ5: reads return bit 14 as 0 while the converter is busy and 1 when it is idle.
// RQ6: writing 1 to bit 14 aborts any running scan or conversion at once, pen down or not, and powers down.
// RQ7: the stop request clears itself after it acts, and writing 0 to it has no effect.
// RQ8: bit 0 of the second command byte makes the same stop and power-down request.
// RQ9: after any reset a read returns 4000h and the written control state is 0000h.
// RQ10: the resolution bit resets to 0 for 10-bit conversions, and 1 selects 12-bit.
// RQ11: once an abort has powered the converter down, reads report the converter idle.
`timescale 1ns/1ps
module tcs_config_status (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          soft_reset,
    input  wire logic [3:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [tcs_pkg::TCS_DATA_W-1:0] reg_wdata,
    input  wire logic                          reg_rd,
    output logic      [tcs_pkg::TCS_DATA_W-1:0] reg_rdata,
    input  wire logic                          cmd1_stop,
    input  wire logic                          pen_touch_in,
    input  wire logic                          conv_busy,
    input  wire logic                          conv_start,
    input  wire logic [3:0]                    converter_function_code,
    output logic                               pen_touch_mode_bit,
    output logic                               auto_scan_enable,
    output logic                               converter_abort,
    output logic                               adc_power_down,
    output logic                               resolution_select,
    output logic      [1:0]                    conversion_clock_divider,
    output logic      [2:0]                    panel_settle_time,
    output logic      [7:0]                    timing_low_fields
);
    import tcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pen input synchronisation
    // the pen level comes straight from the panel comparator and may move
    // at any time, so two flops stand before any logic reads it
    logic                  pen_sync;

    tcs_sync u_pen_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (pen_touch_in),
        .dout (pen_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // written control state
    logic [TCS_DATA_W-1:0] cfg;
    logic [TCS_DATA_W-1:0] next_cfg;
    logic                  cfg_wr;

    // write strobe aimed at this register; other addresses are ignored
    assign cfg_wr = reg_wr && (reg_addr == TCS_ADDR_CFG0);

    // stop bit is never stored; it only raises a request
    // soft reset wins over a write landing in the same cycle
    always_comb begin
        next_cfg = cfg;
        if (soft_reset) begin
            next_cfg = TCS_RESET_WRITE;                              // see RQ9
        end else if (cfg_wr) begin
            next_cfg = reg_wdata;                                    // see RQ2
            next_cfg[TCS_BIT_STOP] = 1'b0;                           // see RQ7
        end
    end

    // control word register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= TCS_RESET_WRITE;                                  // see RQ3
        end else begin
            cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop request flag and abort sequencer
    logic       converter_stop_flag;
    logic       next_converter_stop_flag;
    tcs_state_t state;
    tcs_state_t next_state;
    logic       stop_req;

    // register bit or command byte bit, writing 0 does nothing
    assign stop_req = (cfg_wr && reg_wdata[TCS_BIT_STOP]) || cmd1_stop; // see RQ6, RQ8

    // request seen at edge n: flag from n+1, abort pulse from n+2,
    // power-down from n+3; a request while the flag is pending merges
    // flag set by a request, acted on in the stop state, then cleared
    always_comb begin
        next_converter_stop_flag = converter_stop_flag;
        next_state               = state;
        if (soft_reset) begin
            next_converter_stop_flag = 1'b0;
            next_state               = TCS_ST_RUN;
        end else begin
            case (state)
                TCS_ST_RUN: begin
                    if (converter_stop_flag) begin
                        next_state = TCS_ST_STOP;
                    end
                end
                TCS_ST_STOP: begin
                    next_converter_stop_flag = 1'b0;                 // see RQ7
                    next_state               = TCS_ST_RUN;
                end
                default: begin
                    next_state = TCS_ST_RUN;
                end
            endcase
            // a new request in the clearing cycle is kept
            if (stop_req) begin
                next_converter_stop_flag = 1'b1;
            end
        end
    end

    // stop flag and sequencer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            converter_stop_flag <= 1'b0;
            state               <= TCS_ST_RUN;
        end else begin
            converter_stop_flag <= next_converter_stop_flag;
            state               <= next_state;
        end
    end

    // abort pulse while the flag is acted on
    assign converter_abort = (state == TCS_ST_STOP);                 // see RQ6

    ////////////////////////////////////////////////////////////////////////////
    // converter power-down state
    logic pwr_down;
    logic next_pwr_down;
    logic auto_code_ok;
    logic auto_wake;

    // self scans only with the XYZ or XY code
    assign auto_code_ok = (converter_function_code == TCS_FUNC_XYZ_SCAN) ||
                          (converter_function_code == TCS_FUNC_XY_SCAN); // see RQ4
    // wake may not use auto_scan_enable, which is held off while powered down
    assign auto_wake    = cfg[TCS_BIT_MODE] && auto_code_ok && pen_sync; // see RQ2

    // an abort outranks a wake arriving in the same cycle
    always_comb begin
        next_pwr_down = pwr_down;
        if (soft_reset) begin
            next_pwr_down = 1'b0;
        end else if (state == TCS_ST_STOP) begin
            next_pwr_down = 1'b1;                                    // see RQ6
        end else if (conv_start || auto_wake) begin
            next_pwr_down = 1'b0;                                    // woken by a new conversion
        end
    end

    // power-down register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_down <= 1'b0;
        end else begin
            pwr_down <= next_pwr_down;
        end
    end

    assign adc_power_down = pwr_down;

    ////////////////////////////////////////////////////////////////////////////
    // control outputs
    logic busy_seen;

    // mode bit as written, not the pen status seen on reads
    assign pen_touch_mode_bit       = cfg[TCS_BIT_MODE];             // see RQ2
    // self scans only with the XYZ or XY code and a live converter
    assign auto_scan_enable         = cfg[TCS_BIT_MODE] && !pwr_down && auto_code_ok; // see RQ4

    // stored fields handed to the converter timing logic
    assign resolution_select        = cfg[TCS_BIT_RES];              // see RQ10
    assign conversion_clock_divider = cfg[TCS_CLK_HI:TCS_CLK_LO];
    assign panel_settle_time        = cfg[TCS_SETTLE_HI:TCS_SETTLE_LO];
    assign timing_low_fields        = cfg[TCS_LOW_HI:0];

    // powered-down converter always reads idle
    // the abort cycle is masked too, so a read racing the stop sees idle
    assign busy_seen                = conv_busy && !pwr_down && (state != TCS_ST_STOP); // see RQ11

    ////////////////////////////////////////////////////////////////////////////
    // read data register
    // bits 15 and 14 read live status in place of the stored word;
    // data stands until the next read strobe or soft reset, unknown addresses read zero
    logic [TCS_DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = reg_rdata;
        if (soft_reset) begin
            next_rdata = TCS_RESET_READ;                             // see RQ9
        end else if (reg_rd) begin
            next_rdata = 16'h0000;
            if (reg_addr == TCS_ADDR_CFG0) begin
                next_rdata = cfg;
                next_rdata[TCS_BIT_MODE] = pen_sync;                 // see RQ1
                next_rdata[TCS_BIT_STOP] = !busy_seen;               // see RQ5
            end
        end
    end

    // read data flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= TCS_RESET_READ;                             // see RQ9
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : tcs_config_status

// ---- verif/tcs_chk.sv ----
`timescale 1ns/1ps
// port-level checks of the config/status register
module tcs_chk (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        soft_reset,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        cmd1_stop,
    input wire logic        conv_start,
    input wire logic [3:0]  converter_function_code,
    input wire logic        pen_touch_mode_bit,
    input wire logic        auto_scan_enable,
    input wire logic        converter_abort,
    input wire logic        adc_power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // accepted write and read strobes to address 0
    wire w0 = reg_wr && reg_addr == 4'h0 && !soft_reset;
    wire r0 = reg_rd && reg_addr == 4'h0 && !soft_reset;
    //////////////////////////////////////////////////////////////////////
    a_wr_abort: assert property (w0 && reg_wdata[14] |-> ##2 converter_abort)
        else $error("write stop gave no abort");
    a_cmd_abort: assert property (cmd1_stop && !soft_reset |-> ##2 converter_abort)
        else $error("command stop gave no abort");
    a_abort_pdown: assert property (converter_abort && !soft_reset |=> adc_power_down)
        else $error("abort without power down");
    a_mode_wr: assert property (w0 |=> pen_touch_mode_bit == $past(reg_wdata[15]))
        else $error("mode bit not stored");
    a_rd_idle: assert property (r0 && adc_power_down && !conv_start |=> reg_rdata[14])
        else $error("powered down but read busy");
    a_rd_other: assert property (reg_rd && reg_addr != 4'h0 && !soft_reset |=> reg_rdata == 16'h0000)
        else $error("other address read not zero");
    a_soft_clear: assert property (soft_reset |=> reg_rdata == 16'h4000 && !pen_touch_mode_bit)
        else $error("soft reset values wrong");
    a_auto_gate: assert property (auto_scan_enable |-> pen_touch_mode_bit && !adc_power_down
        && converter_function_code[3:1] == 3'h0)
        else $error("auto scan enabled illegally");
    // main scenarios reached
    c_abort: cover property (converter_abort);
    c_auto: cover property (auto_scan_enable);
    c_pen_read: cover property (r0 ##1 reg_rdata[15]);
    c_auto_wake: cover property (adc_power_down ##1 !adc_power_down && auto_scan_enable);
endmodule : tcs_chk
bind tcs_config_status tcs_chk u_chk (.clk, .rstn, .soft_reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .cmd1_stop, .conv_start, .converter_function_code, .pen_touch_mode_bit, .auto_scan_enable,
    .converter_abort, .adc_power_down);

// ---- verif/tcs_conv_model.sv ----
`timescale 1ns/1ps
// converter stand-in: busy 20 cycles per conversion
module tcs_conv_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic conv_start,
    input  wire logic converter_abort,
    input  wire logic auto_scan_enable,
    input  wire logic pen_touch_in,
    output logic      conv_busy
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    // count down, restart on request, drop on abort
    always_comb begin
        next_cnt = (cnt != 5'h0) ? cnt - 5'h1 : 5'h0;
        if (conv_start || (auto_scan_enable && pen_touch_in && cnt == 5'h0)) next_cnt = 5'h14;
        if (converter_abort) next_cnt = 5'h0;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cnt <= 5'h0;
        else cnt <= next_cnt;
    end
    assign conv_busy = (cnt != 5'h0);
endmodule : tcs_conv_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import tcs_pkg::*;
    logic clk, rstn, soft_reset, reg_wr, reg_rd, cmd1_stop, pen_touch_in, conv_busy, conv_start, rd_seen;
    logic pen_touch_mode_bit, auto_scan_enable, converter_abort, adc_power_down, resolution_select;
    logic [3:0] reg_addr, converter_function_code;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [1:0] conversion_clock_divider;
    logic [2:0] panel_settle_time;
    logic [7:0] timing_low_fields;
    logic [15:0] expq[$];
    int mismatches, total_checks, seed, i;
    tcs_config_status dut (.clk, .rstn, .soft_reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .cmd1_stop, .pen_touch_in, .conv_busy, .conv_start, .converter_function_code, .pen_touch_mode_bit,
        .auto_scan_enable, .converter_abort, .adc_power_down, .resolution_select, .conversion_clock_divider,
        .panel_settle_time, .timing_low_fields);
    tcs_conv_model u_conv (.clk, .rstn, .conv_start, .converter_abort, .auto_scan_enable, .pen_touch_in, .conv_busy);
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // bus strobes, one cycle each, called at a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        expq.push_back(e);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic pulse_start;
        conv_start <= 1'b1;
        @(posedge clk) conv_start <= 1'b0;
        @(posedge clk);
    endtask : pulse_start
    // read data watcher against the oldest note
    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) if (rd_seen) chk("rdata", expq.pop_front(), reg_rdata);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        summarize();
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, soft_reset, reg_wr, reg_rd, cmd1_stop, pen_touch_in, conv_start} = '0;
        reg_addr = 4'h0; reg_wdata = 16'h0000; converter_function_code = 4'h2; seed = 17393;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(4'h0, TCS_RESET_READ);
        chk("mode", 16'h0000, {15'h0, pen_touch_mode_bit});
        // random config words with random pen level
        for (i = 0; i < 8; i++) begin
            pen_touch_in <= 1'($random(seed));
            d = 16'($random(seed));
            wr(4'h0, d);
            chk("cfg", {d[15], 1'b0, d[13:0]}, {pen_touch_mode_bit, 1'b0, resolution_select,
                conversion_clock_divider, panel_settle_time, timing_low_fields});
            rd(4'h0, {pen_touch_in, 1'b1, d[13:0]});
        end
        wr(4'h0, 16'h0000);
        // busy read, then stop by write and by command byte
        for (i = 0; i < 2; i++) begin
            pulse_start();
            rd(4'h0, {pen_touch_in, 15'h0});
            if (i == 0) wr(4'h0, 16'h4000);
            else begin
                cmd1_stop <= 1'b1;
                @(posedge clk) cmd1_stop <= 1'b0;
            end
            for (int n = 0; n < 4 && converter_abort !== 1'b1; n++) @(negedge clk);
            chk("abort", 16'h0001, {15'h0, converter_abort});
            repeat (2) @(posedge clk);
            chk("pdown", 16'h0001, {14'h0, converter_abort, adc_power_down});
            rd(4'h0, {pen_touch_in, 1'b1, 14'h0});
        end
        wr(4'h3, 16'hffff);
        rd(4'h3, 16'h0000);
        rd(4'h0, {pen_touch_in, 1'b1, 14'h0});
        // self-initiated scans only with codes 0000 and 0001
        pen_touch_in <= 1'b1;
        pulse_start();
        wr(4'h0, 16'h8000);
        for (i = 0; i < 4; i++) begin
            converter_function_code <= 4'(i);
            @(negedge clk) chk("auto", {15'h0, i < 2}, {15'h0, auto_scan_enable});
            @(posedge clk);
        end
        // stop in self mode, then the pen wakes the converter into a self scan
        converter_function_code <= TCS_FUNC_XYZ_SCAN;
        wr(4'h0, 16'hc000);
        repeat (4) @(posedge clk);
        rd(4'h0, 16'h8000);
        soft_reset <= 1'b1;
        @(posedge clk) soft_reset <= 1'b0;
        repeat (24) @(posedge clk);
        rd(4'h0, 16'hc000);
        summarize();
    end
endmodule : tb_top
